// >>> src/dac_trim_and_output_control.sv
// Top: register port, trims, I/O port and supply/reset output control
// Function
// - Offset trim eight bits, twos complement
// - Offset applies in eighth-LSB steps, sixteen LSB
// - Fine gain trim six bits, twos complement
// - Three selectable full-scale ranges per channel
// - Supply changing: clamp output, disconnect amp
// - Release only after stable supply, word
// - Reset request low clamps like brownout
// - Supply detector state driven to pin
// - Two I/O bits, independent direction each
// - Host sets outputs, reads input levels
// - Ground correction only while enable set
// - Direction resets input; writes ignored then
// - Gain minus32 to plus31, both ends
// - Range codes 00, 01, 10
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dac_trim_and_output_control
   import dtoc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   input wire logic supplyStable,
   input wire logic ext_reset_request_n,
   output logic supply_detect_out,
   input wire logic [NUM_CHAN*8-1:0] chanGndDelta,
   output logic [NUM_CHAN*16-1:0] analogOutCode,
   output logic [NUM_CHAN*2-1:0] rangeSel,
   output logic [NUM_CHAN-1:0] ampConnectGate,
   output logic [NUM_CHAN-1:0] groundClampGate,
   input wire logic [1:0] ioPortIn,
   output logic [1:0] ioPortOut,
   output logic [1:0] ioPortOe_n
);
   ////////////////////////////////////////////////////////////////////////
   // Register state
   dtoc_trim_t trim_r [NUM_CHAN]; // Per-channel trims
   logic gndEn_r; // Local ground correction enable
   logic [1:0] ioDir_r; // 1 = output
   logic [1:0] ioVal_r; // Output levels
   logic supplyOk; // Supplies stable and no reset request
   assign supplyOk = supplyStable && ext_reset_request_n;
   ////////////////////////////////////////////////////////////////////////
   // Trim registers, one set per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : gChan
         logic wrData;
         assign wrData = regWr && (regAddr == ADDR_DATA0 + 4'(g) ||
                                   (g == 0 && 1'b0));
         always_ff @(posedge core_clk) begin
            if (rst) begin
               trim_r[g] <= '{OFFS_RST, FGAIN_RST, CGAIN_RST};
            end else if (regWr) begin
               if (regAddr == ADDR_OFFS0 + 4'(g)) begin
                  trim_r[g].offs <= regWdata[7:0];
               end
               if (regAddr == ADDR_FGAIN0 + 4'(g)) begin
                  trim_r[g].fgain <= regWdata[5:0];
               end
               if (regAddr == ADDR_CGAIN0 + 4'(g)) begin
                  trim_r[g].cgain <= regWdata[1:0];
               end
            end
         end
         dtoc_chan uChan (
            .core_clk(core_clk),
            .rst(rst),
            .supplyOk(supplyOk),
            .dataWr(wrData),
            .dataIn(regWdata),
            .trim(trim_r[g]),
            .gndEn(gndEn_r),
            .gndDelta(chanGndDelta[g*8 +: 8]),
            .codeOut(analogOutCode[g*16 +: 16]),
            .rangeOut(rangeSel[g*2 +: 2]),
            .ampConnect(ampConnectGate[g]),
            .groundClamp(groundClampGate[g])
         );
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   // Function register: ground enable, I/O direction and values
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gndEn_r <= 1'b0;
         ioDir_r <= 2'b00;
         ioVal_r <= 2'b00;
      end else if (regWr && regAddr == ADDR_FUNC) begin
         gndEn_r <= regWdata[FUNC_GND_BIT];
         ioDir_r <= {regWdata[FUNC_DIR1_BIT], regWdata[FUNC_DIR0_BIT]};
         // Value of an input bit is ignored
         if (regWdata[FUNC_DIR0_BIT]) begin
            ioVal_r[0] <= regWdata[FUNC_VAL0_BIT];
         end
         if (regWdata[FUNC_DIR1_BIT]) begin
            ioVal_r[1] <= regWdata[FUNC_VAL1_BIT];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // I/O pin drive; enable low while driving
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ioPortOut <= 2'b00;
         ioPortOe_n <= 2'b11;
      end else begin
         ioPortOut <= ioVal_r;
         ioPortOe_n <= ~ioDir_r;
      end
   end
   // Supply detector output follows supplyStable alone, not the reset request
   always_ff @(posedge core_clk) begin
      if (rst) begin
         supply_detect_out <= 1'b0;
      end else begin
         supply_detect_out <= supplyStable;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Read port: data the cycle after the strobe, zero otherwise
   logic [1:0] ioLevel;
   assign ioLevel = {ioDir_r[1] ? ioVal_r[1] : ioPortIn[1],
                     ioDir_r[0] ? ioVal_r[0] : ioPortIn[0]};
   always_ff @(posedge core_clk) begin
      if (rst) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         regRdata <= 16'h0000;
         if (regAddr == ADDR_FUNC) begin
            regRdata[FUNC_GND_BIT] <= gndEn_r;
            regRdata[FUNC_DIR0_BIT] <= ioDir_r[0];
            regRdata[FUNC_DIR1_BIT] <= ioDir_r[1];
            regRdata[FUNC_VAL0_BIT] <= ioLevel[0];
            regRdata[FUNC_VAL1_BIT] <= ioLevel[1];
         end else if (regAddr == ADDR_STAT) begin
            regRdata[NUM_CHAN-1:0] <= ampConnectGate;
            regRdata[NUM_CHAN] <= supplyOk;
         end
         // Indices shared with the function and status words read those
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (regAddr == ADDR_DATA0 + 4'(i) && regAddr != ADDR_FUNC &&
                regAddr != ADDR_STAT) begin
               regRdata <= analogOutCode[i*16 +: 16];
            end
            if (regAddr == ADDR_OFFS0 + 4'(i)) begin
               regRdata <= {8'h00, trim_r[i].offs};
            end
            if (regAddr == ADDR_FGAIN0 + 4'(i)) begin
               regRdata <= {10'h000, trim_r[i].fgain};
            end
            if (regAddr == ADDR_CGAIN0 + 4'(i)) begin
               regRdata <= {14'h0000, trim_r[i].cgain};
            end
         end
      end else begin
         regRdata <= 16'h0000;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_input_ignores_val: assert property (@(posedge core_clk) disable iff (rst)
      (regWr && regAddr == ADDR_FUNC && !regWdata[FUNC_DIR0_BIT])
      |=> $stable(ioVal_r[0]))
      else $error("value of input bit changed on write");
   a_dir_to_oe: assert property (@(posedge core_clk) disable iff (rst)
      ioDir_r[1] |=> !ioPortOe_n[1])
      else $error("output bit not driven");
   a_reset_req_clamps: assert property (@(posedge core_clk)
      disable iff (rst)
      !ext_reset_request_n |-> ##2 (groundClampGate == 4'hf))
      else $error("reset request did not clamp");
   a_detect_out: assert property (@(posedge core_clk) disable iff (rst)
      ##1 supply_detect_out == $past(supplyStable))
      else $error("detector pin wrong");
   a_gnd_read: assert property (@(posedge core_clk) disable iff (rst)
      (regRd && regAddr == ADDR_FUNC) |=> regRdata[FUNC_GND_BIT] ==
      $past(gndEn_r))
      else $error("ground enable readback wrong");
endmodule
`default_nettype wire

// >>> src/dtoc_chan.sv
// Per-channel trimmed code and output gate control
`timescale 1ns/1ps
`default_nettype none
module dtoc_chan
   import dtoc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic supplyOk,
   input wire logic dataWr,
   input wire logic [15:0] dataIn,
   input wire dtoc_trim_t trim,
   input wire logic gndEn,
   input wire logic [7:0] gndDelta,
   output logic [15:0] codeOut,
   output logic [1:0] rangeOut,
   output logic ampConnect,
   output logic groundClamp
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] data_r; // Last written code
   logic valid_r; // A word arrived since the last clamp
   dtoc_clamp_t state_r; // Clamp state
   // Eighth-LSB units: code*8 + offset + gain + ground; 22 bits signed
   logic signed [21:0] sum;
   logic signed [21:0] gainTerm;
   always_comb begin
      // Gain moves both ends; scale with sign of code, half step each end
      gainTerm = data_r[15] ? -(22'(signed'(trim.fgain)) <<< 2)
                            : (22'(signed'(trim.fgain)) <<< 2);
      sum = (22'(signed'(data_r)) <<< 3)
          + 22'(signed'(trim.offs))
          + gainTerm
          + (gndEn ? (22'(signed'(gndDelta)) <<< 3) : 22'sh0);
   end
   // Data capture
   always_ff @(posedge core_clk) begin
      if (rst) begin
         data_r <= DATA_RST;
      end else if (dataWr) begin
         data_r <= dataIn;
      end
   end
   // Clamp sequencing: supply loss or reset request clamps at once
   always_ff @(posedge core_clk) begin
      if (rst || !supplyOk) begin
         state_r <= CL_CLAMP;
         valid_r <= 1'b0;
      end else begin
         case (state_r)
            CL_CLAMP: begin
               // Release needs a fresh word after supplies settle
               if (dataWr) begin
                  state_r <= CL_RUN;
                  valid_r <= 1'b1;
               end
            end
            CL_RUN: begin
               state_r <= CL_RUN;
            end
            default: begin
               state_r <= CL_CLAMP;
            end
         endcase
      end
   end
   // Registered outputs, saturating the trimmed code
   always_ff @(posedge core_clk) begin
      if (rst) begin
         codeOut <= DATA_RST;
         rangeOut <= CGAIN_RST;
         ampConnect <= 1'b0;
         groundClamp <= 1'b1;
      end else begin
         if (sum > 22'sh03ffff) begin
            codeOut <= 16'h7fff;
         end else if (sum < -22'sh040000) begin
            codeOut <= 16'h8000;
         end else begin
            codeOut <= sum[18:3];
         end
         // Reserved range code 11 treated as default range
         rangeOut <= (trim.cgain == 2'h3) ? RANGE_10V : trim.cgain;
         ampConnect <= (state_r == CL_RUN) && valid_r && supplyOk;
         groundClamp <= !((state_r == CL_RUN) && valid_r && supplyOk);
      end
   end
   a_clamp_on_loss: assert property (@(posedge core_clk) disable iff (rst)
      !supplyOk |=> ##1 (groundClamp && !ampConnect))
      else $error("output not clamped after supply loss");
   a_release_needs_word: assert property (@(posedge core_clk)
      disable iff (rst)
      $rose(ampConnect) |-> $past(valid_r) || $past(dataWr, 2))
      else $error("output released without a data word");
   a_gates_exclusive: assert property (@(posedge core_clk) disable iff (rst)
      ampConnect != groundClamp)
      else $error("amp and clamp gates both in same state");
endmodule
`default_nettype wire

// >>> src/dtoc_pkg.sv
// Package: constants and types for the converter trim and output control
package dtoc_pkg;
   localparam int NUM_CHAN = 4;
   // Register indices on the plain port
   localparam logic [3:0] ADDR_DATA0 = 4'h0;
   localparam logic [3:0] ADDR_OFFS0 = 4'h4;
   localparam logic [3:0] ADDR_FGAIN0 = 4'h8;
   localparam logic [3:0] ADDR_CGAIN0 = 4'hc;
   localparam logic [3:0] ADDR_FUNC = 4'h1;
   localparam logic [3:0] ADDR_STAT = 4'h2;
   // Function register field positions
   localparam int FUNC_GND_BIT = 0;
   localparam int FUNC_DIR0_BIT = 1;
   localparam int FUNC_DIR1_BIT = 2;
   localparam int FUNC_VAL0_BIT = 3;
   localparam int FUNC_VAL1_BIT = 4;
   // Reset values
   localparam logic [7:0] OFFS_RST = 8'h00;
   localparam logic [5:0] FGAIN_RST = 6'h00;
   localparam logic [1:0] CGAIN_RST = 2'h0;
   localparam logic [15:0] DATA_RST = 16'h0000;
   // Coarse range codes
   localparam logic [1:0] RANGE_10V = 2'h0;
   localparam logic [1:0] RANGE_10V26 = 2'h1;
   localparam logic [1:0] RANGE_10V53 = 2'h2;
   // Per-channel trim set
   typedef struct packed {
      logic [7:0] offs;
      logic [5:0] fgain;
      logic [1:0] cgain;
   } dtoc_trim_t;
   // Output clamp control states
   typedef enum logic [1:0] {
      CL_CLAMP = 2'b01,
      CL_RUN = 2'b10
   } dtoc_clamp_t;
endpackage

// >>> test/dtoc_host.sv
// Host controller model driving the register port of the trim block
`timescale 1ns/1ps
`default_nettype none
module dtoc_host
   import dtoc_pkg::*;
(
   input wire logic core_clk,
   output logic [3:0] regAddr,
   output logic [15:0] regWdata,
   output logic regWr,
   output logic regRd,
   input wire logic [15:0] regRdata
);
   ////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // One-cycle write; the entry edge leaves a gap so strobes never clash
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   // One-cycle read; data stands only in the following cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask
endmodule
`default_nettype wire

// >>> test/tb_dac_trim_and_output_control.sv
// Self-checking bench for the trim and output control block
`timescale 1ns/1ps
`default_nettype none
module tb_dac_trim_and_output_control;
   import dtoc_pkg::*;
   logic core_clk, rst, supplyStable, extRstN; // Clock, reset, supply
   logic [3:0] regAddr;
   logic [15:0] regWdata, regRdata, v;
   logic regWr, regRd, detOut;
   logic [31:0] gndDelta; // Ground difference per channel
   logic [63:0] code;
   logic [7:0] rangeSel;
   logic [3:0] amp, clamp;
   logic [1:0] ioIn, ioOut, ioOe_n, extIo;
   logic [1:0] rng [4]; // Expected range per written code
   int fail_count, n_tests;
   // Pin level: our drive where enabled, else the outside world
   assign ioIn = (~ioOe_n & ioOut) | (ioOe_n & extIo);
   dac_trim_and_output_control i_dut(.core_clk(core_clk), .rst(rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .supplyStable(supplyStable),
      .ext_reset_request_n(extRstN), .supply_detect_out(detOut),
      .chanGndDelta(gndDelta), .analogOutCode(code), .rangeSel(rangeSel),
      .ampConnectGate(amp), .groundClampGate(clamp), .ioPortIn(ioIn),
      .ioPortOut(ioOut), .ioPortOe_n(ioOe_n));
   dtoc_host i_host(.core_clk(core_clk), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata));
   ////////////////////////////////////////////////////////////////////////
   // Clock, 20 ns period
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Compare and count
   task automatic chk(input string n, input logic [15:0] g, e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   // Settle past the edge so flop updates have landed
   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic final_report;
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog: a hang counts as a failure
   initial begin
      #200000;
      fail_count++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1; supplyStable = 1'b0; extRstN = 1'b1;
      gndDelta = 32'h0; extIo = 2'b10; fail_count = 0; n_tests = 0;
      rng = '{RANGE_10V, RANGE_10V26, RANGE_10V53, RANGE_10V};
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk("clamp", {12'h0, clamp}, 16'h000f);
      chk("oe", {14'h0, ioOe_n}, 16'h0003);
      @(posedge core_clk);
      supplyStable <= 1'b1;
      #1;
      chk("det", {15'h0, detOut}, 16'h0000);
      waitc(1);
      chk("det", {15'h0, detOut}, 16'h0001);
      chk("amp", {12'h0, amp}, 16'h0000);
      // Minus two LSB on ch0, plus one LSB on ch3; high bits ignored
      i_host.wr(ADDR_OFFS0, 16'hfff0);
      i_host.wr(ADDR_OFFS0 + 4'h3, 16'h0008);
      i_host.wr(ADDR_DATA0, 16'h1000);
      waitc(1);
      chk("amp", {12'h0, amp}, 16'h0001);
      chk("clamp", {12'h0, clamp}, 16'h000e);
      chk("code0", code[15:0], 16'h0ffe);
      i_host.wr(ADDR_DATA0 + 4'h3, 16'h0100);
      waitc(1);
      chk("code3", code[63:48], 16'h0101);
      i_host.rd(ADDR_DATA0, v);
      chk("rd0", v, 16'h0ffe);
      // Status: channels 0 and 3 connected, supplies good
      i_host.rd(ADDR_STAT, v);
      chk("stat", v, 16'h0019);
      // Each range code, reserved code falls back to default
      for (int i = 0; i < 4; i++) begin
         i_host.wr(ADDR_CGAIN0 + 4'h2, 16'(i));
         waitc(1);
         chk("rng2", {14'h0, rangeSel[5:4]}, {14'h0, rng[i]});
         chk("rng0", {14'h0, rangeSel[1:0]}, 16'h0000);
      end
      // Fine gain at both extremes moves the code
      for (int i = 0; i < 2; i++) begin
         i_host.wr(ADDR_FGAIN0, i ? 16'h001f : 16'h0020);
         i_host.wr(ADDR_DATA0, 16'h1000);
         waitc(1);
         chk("gain", {15'h0, code[15:0] !== 16'h0ffe}, 16'h0001);
      end
      // Values written while input: no drive
      i_host.wr(ADDR_FUNC, 16'h0018);
      waitc(1);
      chk("oe", {14'h0, ioOe_n}, 16'h0003);
      i_host.wr(ADDR_FUNC, 16'h000a);
      waitc(1);
      chk("oe", {14'h0, ioOe_n}, 16'h0002);
      chk("out0", {15'h0, ioOut[0]}, 16'h0001);
      i_host.rd(ADDR_FUNC, v);
      chk("func", v, 16'h001a);
      // Ground difference ignored until enabled
      gndDelta <= 32'h0200_0000;
      waitc(2);
      chk("gndoff", code[63:48], 16'h0101);
      i_host.wr(ADDR_FUNC, 16'h000b);
      i_host.wr(ADDR_DATA0 + 4'h3, 16'h0100);
      waitc(2);
      chk("gndon", {15'h0, code[63:48] !== 16'h0101}, 16'h0001);
      // External reset request clamps; release needs a fresh word
      extRstN <= 1'b0;
      waitc(2);
      chk("xramp", {12'h0, amp}, 16'h0000);
      chk("xrclamp", {12'h0, clamp}, 16'h000f);
      extRstN <= 1'b1;
      waitc(2);
      chk("hold", {12'h0, amp}, 16'h0000);
      i_host.wr(ADDR_DATA0, 16'h1000);
      waitc(1);
      chk("amp", {12'h0, amp}, 16'h0001);
      // Supply loss clamps again
      supplyStable <= 1'b0;
      waitc(2);
      chk("lossamp", {12'h0, amp}, 16'h0000);
      chk("lossclamp", {12'h0, clamp}, 16'h000f);
      final_report();
   end
endmodule
`default_nettype wire
